// ---- shared/strap_defs.svh ----
// Constants for the reset strap sampler
`ifndef STRAP_DEFS_SVH
`define STRAP_DEFS_SVH
`define STRAP_WIDTH_DEF 8
`define STRAP_NOPULL_MASK_DEF 8'hC0
`define STRAP_HOLD_CLKS_DEF 4
`define STRAP_SYNC_STAGES 2
`endif

// ---- shared/strap_pkg.sv ----
// Types shared by the reset strap sampler
package strap_pkg;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_HOLD = 2'b01,
      ST_RUN = 2'b11
   } strap_state_t;
endpackage

// ---- design/strap_pin_cell.sv ----
// One strap pin: capture flop, pad steering and pull control
`timescale 1ns/1ps
`default_nettype none
module strap_pin_cell #(
   parameter logic HAS_PULL = 1'b1
) (
   input wire logic clk,
   input wire logic capture,
   input wire logic in_reset,
   input wire logic pull_on,
   input wire logic pad_in,
   input wire logic func_out,
   output logic cfg_q,
   output logic pad_out_q,
   output logic pad_oe_q,
   output logic pull_en_q
);
   // Latch the pad level once at the deassert edge; held otherwise
   always_ff @(posedge clk) begin
      if (capture) begin
         cfg_q <= pad_in;
      end
   end

   // Pad direction: input in reset, functional output afterward
   always_ff @(posedge clk) begin
      pad_oe_q <= !in_reset;
      pad_out_q <= in_reset ? 1'b0 : func_out;
   end

   // Weak pull only where fitted, and only while the window is open
   always_ff @(posedge clk) begin
      pull_en_q <= HAS_PULL & pull_on;
   end
endmodule
`default_nettype wire

// ---- design/reset_strap_sampler.sv ----
// Power-on strap sampler: captures straps when hard reset releases
`timescale 1ns/1ps
`default_nettype none
`include "strap_defs.svh"
// How it works
// - During hard reset every strap pin is an input, never driven.
// - Pin levels are latched as configuration when hard reset deasserts.
// - Pins return to output use at capture; the receiver turns off after the pull hold window.
// - Weak pull-up is on during reset and a few clocks after, on every pin outside NOPULL_MASK.
// - Receiver disabled means pull-up disabled too.
// - A sampled high selects default; board pulls low for non-default.
// - Outside hard reset strap pins are output-only functional pins.
module reset_strap_sampler #(
   parameter int STRAP_WIDTH = `STRAP_WIDTH_DEF,
   parameter logic [STRAP_WIDTH-1:0] NOPULL_MASK = `STRAP_NOPULL_MASK_DEF,
   parameter int HOLD_CLKS = `STRAP_HOLD_CLKS_DEF
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic hard_reset_n,
   input wire logic [STRAP_WIDTH-1:0] strap_in,
   input wire logic [STRAP_WIDTH-1:0] func_out,
   output logic [STRAP_WIDTH-1:0] strap_out,
   output logic [STRAP_WIDTH-1:0] strap_oe,
   output logic [STRAP_WIDTH-1:0] strap_pull_en,
   output logic [STRAP_WIDTH-1:0] cfg_value,
   output logic rx_en,
   output logic cfg_valid
);
   localparam int CW = $clog2(HOLD_CLKS + 1);

   // Refuse shapes the logic cannot serve
   initial begin
      if (STRAP_WIDTH < 1 || HOLD_CLKS < 1 || HOLD_CLKS > 4096) begin
         $error("reset_strap_sampler: bad parameter");
      end
   end

   strap_pkg::strap_state_t state_q;
   logic hrst_q;
   logic [CW-1:0] cnt_q;
   logic capture;
   logic in_reset;
   logic pull_on;

   // Register the reset pin to find its release edge
   always_ff @(posedge clk) begin
      if (srst) begin
         hrst_q <= 1'b1;
      end else begin
         hrst_q <= !hard_reset_n;
      end
   end

   // Capture on the first cycle hard reset is seen released
   assign capture = hrst_q && hard_reset_n;
   assign in_reset = !hard_reset_n || srst;
   assign pull_on = in_reset || (state_q == strap_pkg::ST_RESET) ||
      (state_q == strap_pkg::ST_HOLD);

   // Sequence: reset, pull hold window, run
   always_ff @(posedge clk) begin
      if (srst || !hard_reset_n) begin
         state_q <= strap_pkg::ST_RESET;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            strap_pkg::ST_RESET: begin
               if (capture) begin
                  state_q <= strap_pkg::ST_HOLD;
                  cnt_q <= CW'(HOLD_CLKS - 1);
               end
            end
            strap_pkg::ST_HOLD: begin
               if (cnt_q == '0) begin
                  state_q <= strap_pkg::ST_RUN;
               end else begin
                  cnt_q <= cnt_q - CW'(1);
               end
            end
            strap_pkg::ST_RUN: begin
               state_q <= strap_pkg::ST_RUN;
            end
            default: begin
               state_q <= strap_pkg::ST_RESET;
            end
         endcase
      end
   end

   // Receiver enable and valid flag
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_en <= 1'b1;
         cfg_valid <= 1'b0;
      end else begin
         rx_en <= pull_on;
         if (!hard_reset_n) begin
            cfg_valid <= 1'b0;
         end else if (capture) begin
            cfg_valid <= 1'b1;
         end
      end
   end

   // One cell per strap pin
   for (genvar i = 0; i < STRAP_WIDTH; i++) begin : g_pin
      strap_pin_cell #(
         .HAS_PULL(!NOPULL_MASK[i])
      ) u_cell (
         .clk(clk),
         .capture(capture),
         .in_reset(in_reset),
         .pull_on(pull_on),
         .pad_in(strap_in[i]),
         .func_out(func_out[i]),
         .cfg_q(cfg_value[i]),
         .pad_out_q(strap_out[i]),
         .pad_oe_q(strap_oe[i]),
         .pull_en_q(strap_pull_en[i])
      );
   end
endmodule
`default_nettype wire

// ---- dv/reset_strap_sampler_chk.sv ----
// Strap sampler checker
`timescale 1ns/1ps
`default_nettype none
module reset_strap_sampler_chk #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] NOPULL_MASK = WIDTH'(8'hC0)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic hard_reset_n,
   input wire logic rx_en,
   input wire logic cfg_valid,
   input wire logic [WIDTH-1:0] strap_in,
   input wire logic [WIDTH-1:0] func_out,
   input wire logic [WIDTH-1:0] strap_out,
   input wire logic [WIDTH-1:0] strap_oe,
   input wire logic [WIDTH-1:0] strap_pull_en,
   input wire logic [WIDTH-1:0] cfg_value
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Hard reset release, then the five-sample pull window
   sequence rel; !hard_reset_n ##1 hard_reset_n; endsequence
   sequence win; (rx_en && strap_pull_en == ~NOPULL_MASK)[*5]
      ##1 (!rx_en && !strap_pull_en); endsequence
   a_oe_rst: assert property (!hard_reset_n |=> !strap_oe)
      else $error("oe");
   a_rx_rst: assert property (!hard_reset_n |=> rx_en && !cfg_valid)
      else $error("rx");
   a_pull_rst:
      assert property (!hard_reset_n |=> strap_pull_en == ~NOPULL_MASK)
      else $error("pull");
   a_cap_val: assert property (rel |=> cfg_value == $past(strap_in))
      else $error("cap");
   a_pull_win: assert property (rel |=> win) else $error("win");
   a_pull_off: assert property (!rx_en |-> !strap_pull_en)
      else $error("off");
   a_out_run:
      assert property (cfg_valid |-> &strap_oe && strap_out == $past(func_out))
      else $error("run");
   a_cfg_hold:
      assert property ($past(cfg_valid) |-> $stable(cfg_value))
      else $error("hold");
endmodule
bind reset_strap_sampler reset_strap_sampler_chk #(
   .WIDTH(STRAP_WIDTH),
   .NOPULL_MASK(NOPULL_MASK)
) reset_strap_sampler_chk_inst (.*);
`default_nettype wire

// ---- dv/strap_board.sv ----
// Board model of the strap resistors
`timescale 1ns/1ps
`default_nettype none
module strap_board (
   input wire logic [7:0] strap_oe,
   input wire logic [7:0] strap_out,
   input wire logic [7:0] strap_pull_en,
   input wire logic [7:0] res,
   output logic [7:0] strap_in
);
   // Pad driver wins; else board pull-down, else a pull-up
   assign strap_in = strap_oe & strap_out
      | ~strap_oe & ~res & (strap_pull_en | 8'hC0);
endmodule
`default_nettype wire

// ---- dv/tb_reset_strap_sampler.sv ----
// Strap sampler bench
`timescale 1ns/1ps
`default_nettype none
module tb_reset_strap_sampler;
   logic clk = 0, srst = 1, hard_reset_n = 0, rx_en, cfg_valid;
   logic [7:0] func_out = 8'h00, res = 8'h00, strap_in, strap_out;
   logic [7:0] strap_oe, strap_pull_en, cfg_value;
   int error_cnt = 0, cmp_count = 0;
   reset_strap_sampler reset_strap_sampler_inst (.*);
   strap_board strap_board_inst (.*);
   initial forever #25 clk = ~clk;
   task automatic chk(string n, logic [7:0] e, s);
      cmp_count++;
      if (s !== e) error_cnt++;
      if (s !== e) $display("[ERR] %s exp %h got %h", n, e, s);
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hard reset pulse; r marks board pull-downs, f the run outputs
   task automatic cyc(logic [7:0] r, f);
      {res, func_out, hard_reset_n} = {r, f, 1'b0};
      repeat (3) @(negedge clk);
      chk("oe", 8'h00, strap_oe);
      chk("pull", 8'h3F, strap_pull_en);
      chk("rx", 8'h01, 8'(rx_en));
      chk("valid0", 8'h00, 8'(cfg_valid));
      hard_reset_n = 1;
      @(negedge clk);
      chk("cfg", ~r, cfg_value);
      chk("out", f, strap_out);
      chk("valid1", 8'h01, 8'(cfg_valid));
      chk("pullwin", 8'h3F, strap_pull_en);
      repeat (7) @(negedge clk);
      chk("pulloff", 8'h00, strap_pull_en);
      chk("rxoff", 8'h00, 8'(rx_en));
      chk("oerun", 8'hFF, strap_oe);
      chk("cfghold", ~r, cfg_value);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      srst = 0;
      cyc(8'h00, 8'h3C);
      cyc(8'hC3, 8'hA5);
      end_sim();
   end
   initial begin
      #5us;
      error_cnt++;
      end_sim();
   end
endmodule
`default_nettype wire
